// *** design/smsp_pkg.sv ***
// types of the servo mode select and pulse input block
// sets the mode and pulse type codes here; other numeric constants come from smsp_regs.svh
package smsp_pkg;
    typedef enum logic [7:0] {
        SMSP_PULSE_POS = 8'h00,
        SMSP_SPEED = 8'h02,
        SMSP_TORQUE = 8'h03,
        SMSP_SPEED_REG = 8'h04,
        SMSP_TORQUE_REG = 8'h05,
        SMSP_POS_SPEED = 8'h06,
        SMSP_POS_TORQUE = 8'h07,
        SMSP_SPEED_TORQUE = 8'h0a
    } smsp_mode_e;
    typedef enum logic [3:0] {
        SMSP_QUAD = 4'h0,
        SMSP_CWCCW = 4'h1,
        SMSP_PULSE_DIR = 4'h2
    } smsp_ptype_e;
    typedef struct packed {
        logic [3:0] source;
        logic [3:0] logic_type;
        logic [3:0] filter;
        logic [3:0] ptype;
    } smsp_cfg_s;
    typedef struct packed {
        logic pos_active;
        logic speed_active;
        logic torque_active;
        logic analog_en;
        logic [1:0] reg_set;
        logic mode_fault;
    } smsp_ctl_s;
endpackage : smsp_pkg

// *** design/smsp_regs.svh ***
// constants of the servo mode select and pulse input block
// assumes a 20 MHz sys_clk; times in ns, counts derived from the period
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH
`define SMSP_CLK_NS 50
`define SMSP_PULSE_CFG_ADDR 16'h0100
`define SMSP_MODE_PARAM_ADDR 16'h0102
`define SMSP_PULSE_CFG_RST 16'h0002
`define SMSP_PULSE_CFG_MAX 16'h1142
`define SMSP_MODE_RST 8'h00
`define SMSP_PTYPE_LSB 0
`define SMSP_FILT_LSB 4
`define SMSP_LOGIC_LSB 8
`define SMSP_SRC_LSB 12
`define SMSP_FILT_OFF 4'h4
`define SMSP_T_HS0_NS 150
`define SMSP_T_HS1_NS 600
`define SMSP_T_HS2_NS 1200
`define SMSP_T_HS3_NS 2400
`define SMSP_T_LS0_NS 600
`define SMSP_T_LS1_NS 2400
`define SMSP_T_LS2_NS 4800
`define SMSP_T_LS3_NS 9600
`define SMSP_CYC(t) (((t) + `SMSP_CLK_NS - 1) / `SMSP_CLK_NS)
`endif

// *** design/smsp_top.sv ***
// control mode selection and pulse command front end of a servo drive
// assumes synchronous pins, a parameter port, and an outside store that keeps
// the control mode across power cycles
`include "smsp_regs.svh"
// ****************************************
// glitch filter for one pulse line
// ****************************************
module smsp_filter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // line
    input wire logic line_in,
    input wire logic bypass,
    input wire logic [7:0] min_cyc,
    output logic line_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_line_out;
    always_comb begin
        next_cnt = 8'h00;
        next_line_out = line_out;
        if (bypass) begin
            next_line_out = line_in;
        end else if (line_in != line_out) begin
            if (cnt >= min_cyc - 8'h01) begin
                next_line_out = line_in;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            line_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            line_out <= next_line_out;
        end
    end
endmodule : smsp_filter
module smsp_top #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // parameter port
    input wire logic par_wr,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic [15:0] par_rdata,
    // persisted control mode
    input wire logic [7:0] stored_mode,
    output logic stored_mode_wr,
    output logic [7:0] stored_mode_data,
    // digital inputs
    input wire logic servo_on_input,
    input wire logic mode_switch_input,
    input wire logic [1:0] reg_set_input,
    // pulse lines
    input wire logic pulse_a,
    input wire logic pulse_b,
    // control results
    output smsp_pkg::smsp_ctl_s ctl,
    output logic [7:0] active_mode,
    output logic signed [CNT_W-1:0] pos_count,
    output logic count_up,
    output logic count_dn
);
    // ****************************************
    // parameters and mode capture
    // ****************************************
    smsp_pkg::smsp_cfg_s cfg;
    smsp_pkg::smsp_cfg_s next_cfg;
    logic [7:0] mode_param;
    logic [7:0] next_mode_param;
    logic [7:0] next_active_mode;
    logic loaded;
    logic next_stored_mode_wr;
    always_comb begin
        next_cfg = cfg;
        next_mode_param = mode_param;
        next_stored_mode_wr = 1'b0;
        next_active_mode = active_mode;
        if (!loaded) begin
            next_active_mode = stored_mode;
            next_mode_param = stored_mode;
        end else if (par_wr && par_addr == `SMSP_PULSE_CFG_ADDR &&
                     par_wdata <= `SMSP_PULSE_CFG_MAX) begin
            next_cfg = par_wdata;
        end else if (par_wr && par_addr == `SMSP_MODE_PARAM_ADDR && !servo_on_input) begin
            // mode is only persisted here; the running mode never moves
            next_mode_param = par_wdata[7:0];
            next_stored_mode_wr = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= `SMSP_PULSE_CFG_RST;
            mode_param <= `SMSP_MODE_RST;
            active_mode <= `SMSP_MODE_RST;
            loaded <= 1'b0;
            stored_mode_wr <= 1'b0;
        end else begin
            cfg <= next_cfg;
            mode_param <= next_mode_param;
            active_mode <= next_active_mode;
            loaded <= 1'b1;
            stored_mode_wr <= next_stored_mode_wr;
        end
    end
    assign stored_mode_data = mode_param;
    always_comb begin
        case (par_addr)
            `SMSP_PULSE_CFG_ADDR: par_rdata = cfg;
            `SMSP_MODE_PARAM_ADDR: par_rdata = {8'h00, mode_param};
            default: par_rdata = 16'h0000;
        endcase
    end

    // ****************************************
    // mode decode
    // ****************************************
    smsp_pkg::smsp_ctl_s next_ctl;
    always_comb begin
        next_ctl = '0;
        next_ctl.reg_set = reg_set_input;
        case (active_mode)
            smsp_pkg::SMSP_PULSE_POS: next_ctl.pos_active = 1'b1;
            smsp_pkg::SMSP_SPEED: begin
                next_ctl.speed_active = 1'b1;
                next_ctl.analog_en = 1'b1;
            end
            smsp_pkg::SMSP_TORQUE: begin
                next_ctl.torque_active = 1'b1;
                next_ctl.analog_en = 1'b1;
            end
            smsp_pkg::SMSP_SPEED_REG: next_ctl.speed_active = 1'b1;
            smsp_pkg::SMSP_TORQUE_REG: next_ctl.torque_active = 1'b1;
            smsp_pkg::SMSP_POS_SPEED: begin
                next_ctl.pos_active = !mode_switch_input;
                next_ctl.speed_active = mode_switch_input;
                next_ctl.analog_en = mode_switch_input;
            end
            smsp_pkg::SMSP_POS_TORQUE: begin
                next_ctl.pos_active = !mode_switch_input;
                next_ctl.torque_active = mode_switch_input;
                next_ctl.analog_en = mode_switch_input;
            end
            smsp_pkg::SMSP_SPEED_TORQUE: begin
                next_ctl.speed_active = !mode_switch_input;
                next_ctl.torque_active = mode_switch_input;
                next_ctl.analog_en = 1'b1;
            end
            default: next_ctl.mode_fault = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    // ****************************************
    // pulse front end
    // ****************************************
    logic [1:0] line_s;
    logic [1:0] next_line_s;
    logic [1:0] line_f;
    logic [1:0] line_d;
    logic [7:0] min_cyc;
    logic bypass;
    // polarity applied at the pin register; 20 MHz sampling bounds the rate
    assign next_line_s = {pulse_b, pulse_a} ^ {2{cfg.logic_type[0]}};
    always_comb begin
        bypass = 1'b0;
        min_cyc = 8'h01;
        case ({cfg.source[0], cfg.filter})
            5'h10: min_cyc = 8'(`SMSP_CYC(`SMSP_T_HS0_NS));
            5'h11: min_cyc = 8'(`SMSP_CYC(`SMSP_T_HS1_NS));
            5'h12: min_cyc = 8'(`SMSP_CYC(`SMSP_T_HS2_NS));
            5'h13: min_cyc = 8'(`SMSP_CYC(`SMSP_T_HS3_NS));
            5'h00: min_cyc = 8'(`SMSP_CYC(`SMSP_T_LS0_NS));
            5'h01: min_cyc = 8'(`SMSP_CYC(`SMSP_T_LS1_NS));
            5'h02: min_cyc = 8'(`SMSP_CYC(`SMSP_T_LS2_NS));
            5'h03: min_cyc = 8'(`SMSP_CYC(`SMSP_T_LS3_NS));
            default: bypass = 1'b1;
        endcase
    end

    for (genvar i = 0; i < 2; i++) begin : g_flt
        smsp_filter u_flt (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .line_in(line_s[i]),
            .bypass(bypass),
            .min_cyc(min_cyc),
            .line_out(line_f[i])
        );
    end
    // ****************************************
    // pulse decode and position count
    // ****************************************
    logic inc;
    logic dec;
    logic signed [CNT_W-1:0] next_pos_count;
    logic [1:0] chg;
    logic [1:0] rise;
    assign chg = line_f ^ line_d;
    assign rise = line_f & ~line_d;
    always_comb begin
        inc = 1'b0;
        dec = 1'b0;
        case (cfg.ptype)
            smsp_pkg::SMSP_QUAD: begin
                // a edge with a != b means a leads: forward
                inc = (chg[0] && (line_f[0] != line_f[1])) ||
                      (chg[1] && (line_f[0] == line_f[1]));
                dec = (chg[0] && (line_f[0] == line_f[1])) ||
                      (chg[1] && (line_f[0] != line_f[1]));
                // both phases moving in one sample carry no direction
                if (chg == 2'b11) {inc, dec} = 2'b00;
            end
            smsp_pkg::SMSP_CWCCW: begin
                inc = rise[0] && !rise[1];
                dec = rise[1] && !rise[0];
            end
            smsp_pkg::SMSP_PULSE_DIR: begin
                inc = rise[0] && !line_f[1];
                dec = rise[0] && line_f[1];
            end
            default: ;
        endcase
        inc = inc && ctl.pos_active;
        dec = dec && ctl.pos_active;
        next_pos_count = pos_count;
        if (inc) begin
            next_pos_count = pos_count + CNT_W'(1);
        end else if (dec) begin
            next_pos_count = pos_count - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_s <= 2'h0;
            line_d <= 2'h0;
            pos_count <= '0;
            count_up <= 1'b0;
            count_dn <= 1'b0;
        end else begin
            line_s <= next_line_s;
            line_d <= line_f;
            pos_count <= next_pos_count;
            count_up <= inc;
            count_dn <= dec;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_quad_a_step;
        cfg.ptype == 4'h0 && ctl.pos_active && chg == 2'b01;
    endsequence
    property p_cfg_range;
        loaded && par_wr && par_addr == `SMSP_PULSE_CFG_ADDR && par_wdata > `SMSP_PULSE_CFG_MAX
            |=> $stable(cfg);
    endproperty
    a_cfg_range: assert property (p_cfg_range) else $error("config over range taken");
    property p_mode_hold;
        loaded && $past(loaded) |-> $stable(active_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("running mode changed");
    property p_pos_only;
        $changed(pos_count) |-> $past(ctl.pos_active);
    endproperty
    a_pos_only: assert property (p_pos_only) else $error("count moved outside position");
    property p_reg_only;
        active_mode == 8'h04 || active_mode == 8'h05 |=> !ctl.analog_en;
    endproperty
    a_reg_only: assert property (p_reg_only) else $error("analog used in register mode");
    property p_dual;
        active_mode == 8'h06 && $stable(active_mode) |=> ctl.pos_active == !$past(mode_switch_input)
            && ctl.speed_active == $past(mode_switch_input);
    endproperty
    a_dual: assert property (p_dual) else $error("dual mode switch wrong");
    property p_src_sel;
        ##1 ctl.speed_active || ctl.torque_active |-> ctl.reg_set == $past(reg_set_input);
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("register set select wrong");
    property p_filter_width;
        $changed(line_f[0]) && !$past(bypass) |-> $past(line_s[0], 1) == line_f[0]
            && $past(line_s[0], 2) == line_f[0] && $past(line_s[0], 3) == line_f[0];
    endproperty
    a_filter_width: assert property (p_filter_width) else $error("narrow pulse passed");
    property p_quad_step;
        s_quad_a_step |=> pos_count != $past(pos_count) && (count_up ^ count_dn);
    endproperty
    a_quad_step: assert property (p_quad_step) else $error("quadrature edge not counted");
    property p_cw;
        cfg.ptype == 4'h1 && ctl.pos_active && rise == 2'b10 |=> pos_count == $past(pos_count) - 1;
    endproperty
    a_cw: assert property (p_cw) else $error("counterclockwise pulse not subtracted");
endmodule : smsp_top

// *** tb/smsp_ctrl_model.sv ***
// motion controller model driving the pulse and sign lines of the drive
// assumes the bench calls idle and burst between quiet periods
// ****************************************
// pulse command source
// ****************************************
module smsp_ctrl_model (
    // clock
    input wire logic sys_clk,
    // pulse lines
    output logic pulse_a,
    output logic pulse_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph;
    initial begin
        ph = 0;
        pulse_a = 1'b0;
        pulse_b = 1'b0;
    end
    // both lines to the inactive level; a phase jump here is settled by the bench
    task automatic idle(input bit pol);
        ph = 0;
        @(posedge sys_clk);
        pulse_a <= pol;
        pulse_b <= pol;
    endtask : idle
    // kind 0 quadrature, 1 separate up and down lines, 2 pulse and direction
    task automatic burst(input int kind, input bit pol, input int n, input bit dn,
                         input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            if (kind == 0) begin
                ph = dn ? (ph + 3) % 4 : (ph + 1) % 4;
                @(posedge sys_clk);
                pulse_a <= (ph == 1 || ph == 2) ^ pol;
                pulse_b <= (ph >= 2) ^ pol;
                repeat (hi - 1) @(posedge sys_clk);
            end else begin
                @(posedge sys_clk);
                pulse_a <= pol;
                pulse_b <= (kind == 2) ? dn ^ pol : pol;
                repeat (lo) @(posedge sys_clk);
                if (kind == 1 && dn) pulse_b <= ~pol;
                else pulse_a <= ~pol;
                repeat (hi - 1) @(posedge sys_clk);
            end
        end
        if (kind != 0) begin
            @(posedge sys_clk);
            pulse_a <= pol;
            if (kind == 1) pulse_b <= pol;
        end
    endtask : burst
endmodule : smsp_ctrl_model

// *** tb/tb_top.sv ***
// self-checking bench of the mode select and pulse input block
// assumes a 50 ns clock and the controller model on the pulse lines
// ****************************************
// bench top
// ****************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] CFG_ADDR = 16'h0100;
    localparam logic [15:0] MODE_ADDR = 16'h0102;
    logic sys_clk = 1'b0;
    logic arst_n, par_wr, stored_mode_wr, servo_on_input, mode_switch_input;
    logic [15:0] par_addr, par_wdata, par_rdata;
    logic [7:0] stored_mode, stored_mode_data, active_mode;
    logic [1:0] reg_set_input;
    logic pulse_a, pulse_b, count_up, count_dn;
    logic signed [31:0] pos_count;
    smsp_pkg::smsp_ctl_s ctl;
    int n_checks = 0;
    int n_mismatch = 0;
    int up_seen = 0;
    int dn_seen = 0;
    int hs_ns[4] = '{150, 600, 1200, 2400};
    int ls_ns[4] = '{600, 2400, 4800, 9600};
    logic [7:0] codes[10] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0a,
                              8'h0b, 8'h0c};
    smsp_top #(.CNT_W(32)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .par_wr(par_wr),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .stored_mode(stored_mode), .stored_mode_wr(stored_mode_wr),
        .stored_mode_data(stored_mode_data), .servo_on_input(servo_on_input),
        .mode_switch_input(mode_switch_input), .reg_set_input(reg_set_input),
        .pulse_a(pulse_a), .pulse_b(pulse_b), .ctl(ctl), .active_mode(active_mode),
        .pos_count(pos_count), .count_up(count_up), .count_dn(count_dn));
    smsp_ctrl_model u_ctrl (.sys_clk(sys_clk), .pulse_a(pulse_a), .pulse_b(pulse_b));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (count_up === 1'b1) up_seen++;
        if (count_dn === 1'b1) dn_seen++;
    end
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // the stored code stands in for the value kept across a power cycle
    task automatic do_reset(input logic [7:0] mode);
        @(posedge sys_clk);
        stored_mode <= mode;
        arst_n <= 1'b0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask : do_reset
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        par_wr <= 1'b1;
        par_addr <= a;
        par_wdata <= d;
        @(posedge sys_clk);
        par_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk);
        par_addr <= a;
        @(negedge sys_clk);
        check_val(what, exp, par_rdata);
    endtask : rd
    function automatic logic [4:0] exp_ctl(input logic [7:0] m, input logic sw);
        case (m)
            8'h00: return 5'b10000;
            8'h02: return 5'b01010;
            8'h03: return 5'b00110;
            8'h04: return 5'b01000;
            8'h05: return 5'b00100;
            8'h06: return sw ? 5'b01010 : 5'b10000;
            8'h07: return sw ? 5'b00110 : 5'b10000;
            8'h0a: return sw ? 5'b00110 : 5'b01010;
            default: return 5'b00001;
        endcase
    endfunction : exp_ctl
    task automatic pulse_run(input int kind, input bit pol, input int n, input bit dn,
                             input int hi, input int lo, input int exp, input int settle);
        logic signed [31:0] p0;
        int u0;
        int d0;
        repeat (settle) @(posedge sys_clk);
        @(negedge sys_clk);
        p0 = pos_count;
        u0 = up_seen;
        d0 = dn_seen;
        u_ctrl.burst(kind, pol, n, dn, hi, lo);
        repeat (settle) @(posedge sys_clk);
        @(negedge sys_clk);
        check_val("position delta", exp, pos_count - p0);
        check_val("step pulses", (exp < 0) ? -exp : exp, dn ? dn_seen - d0 : up_seen - u0);
    endtask : pulse_run
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        logic [4:0] e;
        int n;
        int c;
        bit d;
        arst_n = 1'b0;
        par_wr = 1'b0;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
        stored_mode = 8'h00;
        servo_on_input = 1'b0;
        mode_switch_input = 1'b0;
        reg_set_input = 2'h0;
        void'($urandom(4));
        do_reset(8'h00);
        rd(CFG_ADDR, 16'h0002, "config reset");
        rd(16'h0104, 16'h0000, "unmapped read");
        wr(CFG_ADDR, 16'h1143);
        rd(CFG_ADDR, 16'h0002, "config over range");
        wr(CFG_ADDR, 16'h1142);
        rd(CFG_ADDR, 16'h1142, "config top");
        @(posedge sys_clk) servo_on_input <= 1'b1;
        wr(MODE_ADDR, 16'h0002);
        @(negedge sys_clk);
        check_val("mode store while on", 1'b0, stored_mode_wr);
        rd(MODE_ADDR, 16'h0000, "mode while on");
        @(posedge sys_clk) servo_on_input <= 1'b0;
        wr(MODE_ADDR, 16'h0002);
        @(negedge sys_clk);
        check_val("mode store", 9'h102, {stored_mode_wr, stored_mode_data});
        @(negedge sys_clk);
        check_val("mode store end", 1'b0, stored_mode_wr);
        rd(MODE_ADDR, 16'h0002, "mode param");
        check_val("running before restart", 8'h00, active_mode);
        foreach (codes[i]) begin
            do_reset(codes[i]);
            for (int sw = 0; sw < 2; sw++) begin
                @(posedge sys_clk);
                mode_switch_input <= sw[0];
                reg_set_input <= 2'($urandom % 3);
                repeat (4) @(posedge sys_clk);
                @(negedge sys_clk);
                e = exp_ctl(codes[i], sw[0]);
                check_val("control select", {e[4:2], e[0]}, {ctl.pos_active, ctl.speed_active,
                          ctl.torque_active, ctl.mode_fault});
                if (e[0] == 1'b0) check_val("running mode", codes[i], active_mode);
                if (e[3] | e[2]) begin
                    check_val("analog source", e[1], ctl.analog_en);
                    check_val("register set", reg_set_input, ctl.reg_set);
                end
            end
        end
        do_reset(8'h00);
        // no filter so that bursts at the full 4 Mpps rate get through
        for (int k = 0; k < 3; k++) begin
            for (int pol = 0; pol < 2; pol++) begin
                wr(CFG_ADDR, 16'(pol * 256 + 64 + k));
                u_ctrl.idle(pol[0]);
                n = 1 + $urandom % 20;
                d = 1'($urandom % 2);
                pulse_run(k, pol[0], n, d, 2 + $urandom % 2, 3, d ? -n : n, 8);
            end
        end
        // fixed runs so that every decoder sees both directions, whatever the seed draws
        for (int k = 0; k < 6; k++) begin
            wr(CFG_ADDR, 16'(64 + k % 3));
            u_ctrl.idle(1'b0);
            pulse_run(k % 3, 1'b0, 5, 1'(k / 3), 2, 3, (k / 3) ? -5 : 5, 8);
        end
        wr(CFG_ADDR, 16'h0043);
        u_ctrl.idle(1'b0);
        pulse_run(2, 1'b0, 4, 1'b0, 2, 3, 0, 8);
        for (int hs = 0; hs < 2; hs++) begin
            for (int f = 0; f < 4; f++) begin
                c = (hs ? hs_ns[f] : ls_ns[f]) / 50;
                wr(CFG_ADDR, 16'(hs * 4096 + f * 16 + 2));
                pulse_run(2, 1'b0, 3, 1'b0, c - 1, c + 1, 0, c + 8);
                pulse_run(2, 1'b0, 3, 1'b0, c + 1, c + 1, 3, c + 8);
                pulse_run(2, 1'b0, 2, 1'b0, c + 1, c - 1, 1, c + 8);
            end
        end
        do_reset(8'h02);
        wr(CFG_ADDR, 16'h0042);
        pulse_run(2, 1'b0, 5, 1'b0, 2, 3, 0, 8);
        report_and_stop();
    end
endmodule : tb_top
